/* File: core/rpc_port_ctl.sv */
// root port 2 power/reset/resume control: avalon-mm slave and port signalling sequencer
// assumes a synchronous avalon master and a port suspend request from the rest of the port
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "rpc_cfg.svh"

// Behaviour
// - A read of the power bit returns 1 when port power is marked enabled, else 0.
// - Writing 1 to the power bit sets the stored power state, writing 0 leaves it.
// - No output drives external port power; the power bits are bookkeeping only.
// - A read of the reset bit returns 1 while reset signalling is driven, else 0.
// - Writing 1 to the reset bit sets it and starts reset signalling; 0 is ignored.
// - There is no overcurrent input, so the overcurrent indicator always reads 0.
// - Writing 1 to the clear-suspend bit while suspended and with no reset signalled or requested starts resume signalling.
// - That write of 1 is ignored when not suspended, and a write of 0 always is.
// - The suspend state clears at the end of a resume sequence and of a reset sequence.
// - The reset change flag sets when the reset bit changes and clears on a write of 1.
module rpc_port_ctl
   import rpc_pkg::*;
#(
   parameter int RESET_CYCLES = `RPC_RESET_TIME_MS * 1000 * `RPC_CLK_MHZ,
   parameter int RESUME_CYCLES = `RPC_RESUME_TIME_MS * 1000 * `RPC_CLK_MHZ
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [3:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic suspend_set_i,
   output logic suspend_state_o,
   output logic usb_reset_drive_o,
   output logic usb_resume_drive_o
);

   // *****************************************************************
   // reset release
   // *****************************************************************
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // a write bit counts only when its byte lane is enabled
   function automatic logic lane_bit(input logic [31:0] data, input logic [3:0] be,
                                     input int pos);
      lane_bit = data[pos] & be[pos / 8];
   endfunction

   // *****************************************************************
   // avalon slave handshake
   // *****************************************************************
   logic hit;
   logic wr_take;
   logic rd_take;
   logic next_waitrequest;
   logic [31:0] next_readdata;
   logic port_power_flag;
   logic port_reset_flag;
   logic suspend_state_flag;
   logic reset_change_flag;

   assign hit = (address_i == `RPC_PORT_STATUS_OFS);
   // one wait state: the request is seen, then accepted on the next edge
   assign wr_take = write_i & ~waitrequest_o;
   assign rd_take = read_i & waitrequest_o;

   always_comb begin
      next_waitrequest = 1'b1;
      if ((read_i | write_i) & waitrequest_o) begin
         next_waitrequest = 1'b0;
      end
      next_readdata = readdata_o;
      if (rd_take) begin
         next_readdata = '0;
         if (hit) begin
            next_readdata[`RPC_POWER_BIT] = port_power_flag;
            next_readdata[`RPC_RESET_BIT] = port_reset_flag;
            next_readdata[`RPC_RESUME_BIT] = 1'b0;
            next_readdata[`RPC_SUSPEND_BIT] = suspend_state_flag;
            next_readdata[`RPC_RESET_CHG_BIT] = reset_change_flag;
            next_readdata[`RPC_RSVD_HI_BIT:`RPC_RSVD_LO_BIT] = 3'h0;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_sync) begin
      if (!rst_sync) begin
         waitrequest_o <= 1'b1;
         readdata_o <= `RPC_READDATA_RST;
      end else begin
         waitrequest_o <= next_waitrequest;
         readdata_o <= next_readdata;
      end
   end

   // *****************************************************************
   // decoded write strobes
   // *****************************************************************
   logic wr_port;
   logic set_power;
   logic clr_power;
   logic set_reset;
   logic req_resume;
   logic clr_change;

   assign wr_port = wr_take & hit;
   assign set_power = wr_port & lane_bit(writedata_i, byteenable_i, `RPC_POWER_BIT);
   assign clr_power = wr_port & lane_bit(writedata_i, byteenable_i, `RPC_POWER_CLR_BIT);
   assign set_reset = wr_port & lane_bit(writedata_i, byteenable_i, `RPC_RESET_BIT);
   assign req_resume = wr_port & lane_bit(writedata_i, byteenable_i, `RPC_RESUME_BIT);
   assign clr_change = wr_port & lane_bit(writedata_i, byteenable_i, `RPC_RESET_CHG_BIT);

   // *****************************************************************
   // signalling sequencer
   // *****************************************************************
   rpc_phase_type phase;
   rpc_phase_type next_phase;
   logic timer_start;
   logic [`RPC_TIMER_W-1:0] timer_load;
   logic timer_done;
   logic next_reset_drive;
   logic next_resume_drive;

   // reset outranks resume; a reset request also restarts a running reset
   always_comb begin
      next_phase = phase;
      timer_start = 1'b0;
      timer_load = `RPC_TIMER_W'(RESET_CYCLES);
      if (set_reset) begin
         next_phase = RPC_RESETTING;
         timer_start = 1'b1;
      end else begin
         unique case (phase)
            RPC_IDLE: begin
               if (req_resume & suspend_state_flag) begin
                  next_phase = RPC_RESUMING;
                  timer_start = 1'b1;
                  timer_load = `RPC_TIMER_W'(RESUME_CYCLES);
               end
            end
            RPC_RESETTING: begin
               if (timer_done) begin
                  next_phase = RPC_IDLE;
               end
            end
            RPC_RESUMING: begin
               if (timer_done) begin
                  next_phase = RPC_IDLE;
               end
            end
         endcase
      end
      next_reset_drive = (next_phase == RPC_RESETTING);
      next_resume_drive = (next_phase == RPC_RESUMING);
   end

   always_ff @(posedge clk_sys_i or negedge rst_sync) begin
      if (!rst_sync) begin
         phase <= RPC_IDLE;
         usb_reset_drive_o <= 1'b0;
         usb_resume_drive_o <= 1'b0;
      end else begin
         phase <= next_phase;
         usb_reset_drive_o <= next_reset_drive;
         usb_resume_drive_o <= next_resume_drive;
      end
   end

   rpc_timer #(
      .W(`RPC_TIMER_W)
   ) u_timer (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_sync),
      .start_i(timer_start),
      .load_i(timer_load),
      .done_o(timer_done)
   );

   // *****************************************************************
   // status flags
   // *****************************************************************
   logic next_power;
   logic next_reset;
   logic next_suspend;
   logic next_change;
   logic seq_end;

   assign seq_end = timer_done & (phase != RPC_IDLE) & ~set_reset;

   // power state is never driven out of the block, only read back
   always_comb begin
      next_power = port_power_flag;
      if (set_power) begin
         next_power = 1'b1;
      end else if (clr_power) begin
         next_power = 1'b0;
      end
      next_reset = next_reset_drive;
      next_suspend = suspend_state_flag;
      if (suspend_set_i) begin
         next_suspend = 1'b1;
      end
      // the end of a sequence leaves the port awake whatever else arrives
      if (seq_end) begin
         next_suspend = 1'b0;
      end
      next_change = reset_change_flag;
      if (clr_change) begin
         next_change = 1'b0;
      end
      if (next_reset != port_reset_flag) begin
         next_change = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_sync) begin
      if (!rst_sync) begin
         port_power_flag <= `RPC_POWER_RST;
         port_reset_flag <= `RPC_RESET_RST;
         suspend_state_flag <= `RPC_SUSPEND_RST;
         reset_change_flag <= `RPC_RESET_CHG_RST;
      end else begin
         port_power_flag <= next_power;
         port_reset_flag <= next_reset;
         suspend_state_flag <= next_suspend;
         reset_change_flag <= next_change;
      end
   end

   assign suspend_state_o = suspend_state_flag;

   // *****************************************************************
   // checks
   // *****************************************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_sync);

   sequence port_read_s;
      rd_take && hit;
   endsequence

   sequence power_write_s;
      set_power;
   endsequence

   sequence reset_write_s;
      set_reset;
   endsequence

   sequence resume_write_s;
      req_resume && !set_reset && phase == RPC_IDLE;
   endsequence

   power_read_a: assert property (
      port_read_s |=> readdata_o[`RPC_POWER_BIT] == $past(port_power_flag))
      else $error("power bit read back wrong");

   power_set_a: assert property (
      power_write_s |=> port_power_flag ##1 port_power_flag || clr_power)
      else $error("power bit not set by write");

   power_keep_a: assert property (
      wr_port && !set_power && !clr_power |=> port_power_flag == $past(port_power_flag))
      else $error("power bit changed by write of zero");

   reset_read_a: assert property (
      port_read_s |=> readdata_o[`RPC_RESET_BIT] == $past(usb_reset_drive_o))
      else $error("reset bit does not follow reset signalling");

   reset_start_a: assert property (
      reset_write_s |=> port_reset_flag && usb_reset_drive_o && !usb_resume_drive_o)
      else $error("reset signalling did not start");

   reset_ignore_a: assert property (
      wr_port && !set_reset && !port_reset_flag |=> !port_reset_flag)
      else $error("write of zero started reset");

   overcurrent_zero_a: assert property (
      port_read_s |=> readdata_o[`RPC_RESUME_BIT] == 1'b0)
      else $error("overcurrent indicator read as one");

   resume_start_a: assert property (
      resume_write_s ##0 suspend_state_flag |=> usb_resume_drive_o && suspend_state_flag)
      else $error("resume signalling did not start");

   resume_ignore_a: assert property (
      resume_write_s ##0 !suspend_state_flag |=> !usb_resume_drive_o)
      else $error("resume started while not suspended");

   suspend_end_a: assert property (
      seq_end |=> !suspend_state_flag && !usb_resume_drive_o)
      else $error("suspend state survived end of sequence");

   change_set_a: assert property (
      $changed(port_reset_flag) |-> reset_change_flag)
      else $error("reset change flag missed a change");

   reset_end_a: assert property (
      phase == RPC_RESETTING && timer_done && !set_reset |=>
         !port_reset_flag ##1 (!port_reset_flag || $past(set_reset)))
      else $error("reset signalling did not end");

   reserved_zero_a: assert property (
      port_read_s |=> readdata_o[`RPC_RSVD_HI_BIT:`RPC_RSVD_LO_BIT] == 3'h0)
      else $error("reserved bits read nonzero");

endmodule

/* File: core/rpc_cfg.svh */
// root port 2 power/reset/resume control: offsets, field positions, reset values, timing
// assumes inclusion by bare name from files under core/
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH

// *****************************************************************
// register map (byte addresses on the avalon slave)
// *****************************************************************
`define RPC_PORT_STATUS_OFS 4'h0

// *****************************************************************
// field positions in root_port2_status_control
// *****************************************************************
`define RPC_SUSPEND_BIT 2
`define RPC_RESUME_BIT 3
`define RPC_RESET_BIT 4
`define RPC_RSVD_LO_BIT 5
`define RPC_RSVD_HI_BIT 7
`define RPC_POWER_BIT 8
`define RPC_POWER_CLR_BIT 9
`define RPC_RESET_CHG_BIT 20

// *****************************************************************
// reset values
// *****************************************************************
`define RPC_POWER_RST 1'b0
`define RPC_RESET_RST 1'b0
`define RPC_SUSPEND_RST 1'b0
`define RPC_RESET_CHG_RST 1'b0
`define RPC_READDATA_RST 32'h00000000

// *****************************************************************
// timing
// *****************************************************************
`define RPC_CLK_MHZ 250
`define RPC_RESET_TIME_MS 50
`define RPC_RESUME_TIME_MS 20
`define RPC_TIMER_W 24

`endif

/* File: core/rpc_pkg.sv */
// root port 2 power/reset/resume control: shared types
// assumes no other package
package rpc_pkg;

   // one-hot signalling phase of the port
   typedef enum logic [2:0] {
      RPC_IDLE = 3'b001,
      RPC_RESETTING = 3'b010,
      RPC_RESUMING = 3'b100
   } rpc_phase_type;

endpackage

/* File: core/rpc_timer.sv */
// root port 2 power/reset/resume control: down-counter for signalling durations
// assumes a synchronous start pulse and an already synchronised reset
`timescale 1ns/100ps

module rpc_timer #(
   parameter int W = 24
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [W-1:0] load_i,
   output logic done_o
);

   logic [W-1:0] count;
   logic running;
   logic [W-1:0] next_count;
   logic next_running;
   logic next_done;

   // a new start restarts the count even while one is running
   always_comb begin
      next_count = count;
      next_running = running;
      next_done = 1'b0;
      if (start_i) begin
         next_count = load_i;
         next_running = 1'b1;
      end else if (running) begin
         if (count <= W'(1)) begin
            next_running = 1'b0;
            next_done = 1'b1;
         end else begin
            next_count = count - W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= '0;
         running <= 1'b0;
         done_o <= 1'b0;
      end else begin
         count <= next_count;
         running <= next_running;
         done_o <= next_done;
      end
   end

endmodule

/* File: sim/rpc_usb_dev_model.sv */
// downstream device model on root port 2: times reset and resume signalling
// assumes drive levels registered on the system clock, raw active-low reset
`timescale 1ns/100ps

module rpc_usb_dev_model (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic reset_drive_i,
   input wire logic resume_drive_i,
   output logic [31:0] reset_len_o,
   output logic [31:0] resume_len_o,
   output logic overlap_o
);
   logic [31:0] reset_cnt;
   logic [31:0] resume_cnt;
   logic reset_prev;
   logic resume_prev;

   // only durations and reset/resume overlap matter to the device; line states are not modelled
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reset_cnt <= 32'h0;
         resume_cnt <= 32'h0;
         reset_prev <= 1'b0;
         resume_prev <= 1'b0;
         reset_len_o <= 32'h0;
         resume_len_o <= 32'h0;
         overlap_o <= 1'b0;
      end else begin
         reset_prev <= reset_drive_i;
         resume_prev <= resume_drive_i;
         reset_cnt <= reset_drive_i ? reset_cnt + 32'h1 : 32'h0;
         resume_cnt <= resume_drive_i ? resume_cnt + 32'h1 : 32'h0;
         if (reset_prev && !reset_drive_i) begin
            reset_len_o <= reset_cnt;
         end
         if (resume_prev && !resume_drive_i) begin
            resume_len_o <= resume_cnt;
         end
         // a device cannot make sense of reset and resume at once
         if (reset_drive_i && resume_drive_i) begin
            overlap_o <= 1'b1;
         end
      end
   end
endmodule

/* File: sim/root_port_power_reset_resume_ctl_tb.sv */
// testbench for the root port 2 power/reset/resume control
// assumes rpc_port_ctl with short signalling counts and the device model beside it
`timescale 1ns/100ps

module root_port_power_reset_resume_ctl_tb;
   typedef struct {
      logic [3:0] wa;
      logic [31:0] wd;
      logic [3:0] be;
      logic [3:0] ra;
      logic [31:0] exp;
   } rpc_row_type;

   localparam int RST_CYC = 20;
   localparam int RES_CYC = 10;

   logic clk_sys_i, rst_n_i, read_i, write_i, suspend_set_i;
   logic [3:0] address_i, byteenable_i;
   logic [31:0] writedata_i, readdata_o, rd, reset_len, resume_len;
   logic waitrequest_o, suspend_state_o, usb_reset_drive_o, usb_resume_drive_o, overlap;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;

   // ordinary cases: write, then read back
   rpc_row_type rows [9] = '{
      '{4'h0, 32'h00000000, 4'hF, 4'h0, 32'h00000000},
      '{4'h0, 32'h00000100, 4'hD, 4'h0, 32'h00000000},
      '{4'h0, 32'h00000100, 4'hF, 4'h0, 32'h00000100},
      '{4'h0, 32'h000000E0, 4'hF, 4'h0, 32'h00000100},
      '{4'h0, 32'h00000200, 4'hF, 4'h0, 32'h00000000},
      '{4'h0, 32'h00000300, 4'hF, 4'h0, 32'h00000100},
      '{4'h4, 32'hFFFFFFFF, 4'hF, 4'h4, 32'h00000000},
      '{4'h0, 32'h00000008, 4'hF, 4'h0, 32'h00000100},
      '{4'h0, 32'h00000010, 4'hE, 4'h0, 32'h00000100}
   };

   rpc_port_ctl #(.RESET_CYCLES(RST_CYC), .RESUME_CYCLES(RES_CYC)) dut_u (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .suspend_set_i(suspend_set_i),
      .suspend_state_o(suspend_state_o), .usb_reset_drive_o(usb_reset_drive_o),
      .usb_resume_drive_o(usb_resume_drive_o));

   rpc_usb_dev_model dev_u (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reset_drive_i(usb_reset_drive_o),
      .resume_drive_i(usb_resume_drive_o), .reset_len_o(reset_len),
      .resume_len_o(resume_len), .overlap_o(overlap));

   always #2 clk_sys_i = ~clk_sys_i;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request held until waitrequest is sampled low, released at that edge, then one idle edge
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      address_i <= a;
      writedata_i <= d;
      byteenable_i <= be;
      write_i <= 1'b1;
      @(posedge clk_sys_i);
      while (waitrequest_o !== 1'b0) @(posedge clk_sys_i);
      write_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      address_i <= a;
      read_i <= 1'b1;
      @(posedge clk_sys_i);
      while (waitrequest_o !== 1'b0) @(posedge clk_sys_i);
      d = readdata_o;
      read_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic pulse_suspend;
      suspend_set_i <= 1'b1;
      @(posedge clk_sys_i);
      suspend_set_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // whole run needs well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      clk_sys_i = 1'b0;
      rst_n_i = 1'b0;
      read_i = 1'b0;
      write_i = 1'b0;
      address_i = 4'h0;
      writedata_i = 32'h0;
      byteenable_i = 4'h0;
      suspend_set_i = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      bus_rd(4'h0, rd);
      check(rd, 32'h00000000);
      foreach (rows[i]) begin
         bus_wr(rows[i].wa, rows[i].wd, rows[i].be);
         bus_rd(rows[i].ra, rd);
         check(rd, rows[i].exp);
      end
      check({30'h0, usb_resume_drive_o, usb_reset_drive_o}, 32'h0);
      $display("test rows done");

      bus_wr(4'h0, 32'h00000010, 4'hF);
      bus_rd(4'h0, rd);
      check(rd, 32'h00100110);
      bus_wr(4'h0, 32'h00100000, 4'hF);
      bus_rd(4'h0, rd);
      check(rd, 32'h00000110);
      while (usb_reset_drive_o === 1'b1) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      check({31'h0, reset_len >= RST_CYC && reset_len <= RST_CYC + 4}, 32'h1);
      bus_rd(4'h0, rd);
      check(rd, 32'h00100100);
      bus_wr(4'h0, 32'h00100000, 4'hF);
      bus_rd(4'h0, rd);
      check(rd, 32'h00000100);
      $display("test reset done");

      pulse_suspend();
      bus_rd(4'h0, rd);
      check(rd, 32'h00000104);
      bus_wr(4'h0, 32'h00000000, 4'hF);
      check({31'h0, usb_resume_drive_o}, 32'h0);
      bus_wr(4'h0, 32'h00000008, 4'hF);
      check({31'h0, usb_resume_drive_o}, 32'h1);
      bus_rd(4'h0, rd);
      check(rd, 32'h00000104);
      while (usb_resume_drive_o === 1'b1) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      check({31'h0, resume_len >= RES_CYC && resume_len <= RES_CYC + 4}, 32'h1);
      check({31'h0, suspend_state_o}, 32'h0);
      $display("test resume done");

      pulse_suspend();
      bus_wr(4'h0, 32'h00000010, 4'hF);
      bus_wr(4'h0, 32'h00000008, 4'hF);
      check({31'h0, usb_resume_drive_o}, 32'h0);
      while (usb_reset_drive_o === 1'b1) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      check({31'h0, suspend_state_o}, 32'h0);
      $display("test suspend reset done");

      // reset in mid-sequence must drop the drive and clear the stored power
      bus_wr(4'h0, 32'h00000010, 4'hF);
      rst_n_i <= 1'b0;
      @(posedge clk_sys_i);
      check({31'h0, usb_reset_drive_o}, 32'h0);
      check(readdata_o, 32'h00000000);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      bus_rd(4'h0, rd);
      check(rd, 32'h00000000);
      check({31'h0, overlap}, 32'h0);
      $display("test midrun reset done");
      report_and_stop();
   end
endmodule
